//--- hw/clsb_pkg.sv
// package for the current-loop serial buffer: frame, buffer and timing constants
// assumes a 10 MHz system clock and classic wishbone register access
package clsb_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int RX_DEPTH = 128;
  localparam int TX_DEPTH = 256;
  localparam int TX_MAX_LEN = 255;
  localparam logic [7:0] CH_NULL = 8'h00;
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_CTRL_N = 8'h0e;
  localparam logic [7:0] CH_CTRL_T = 8'h14;
  localparam logic [7:0] CH_ESC = 8'h1b;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] TERM_MIN = 8'h01;
  localparam logic [7:0] TERM_MAX = 8'h40;
  localparam logic [7:0] TERM_RESET = 8'h2a;
  // transmit delay step 0.01 s, setting 0..250
  localparam int TX_DLY_STEP_MS = 10;
  localparam int TX_DLY_STEP_CYC = CLK_HZ / 1000 * TX_DLY_STEP_MS;
  localparam logic [7:0] TX_DLY_MAX = 8'hfa;
  // baud index 0..7 = 300..38400
  localparam int BAUD_300_CYC = CLK_HZ / 300;
  // register word offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TERM = 8'h04;
  localparam logic [7:0] REG_DELAY = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RXDATA = 8'h10;
  localparam logic [7:0] REG_TXDATA = 8'h14;
  localparam logic [7:0] REG_TXCMD = 8'h18;
  // ctrl fields
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_SEVEN = 3;
  localparam int CTRL_PAR_EN = 4;
  localparam int CTRL_PAR_ODD = 5;
  localparam int CTRL_LOOPMODE = 6;
  localparam int CTRL_COLLECT = 7;
  localparam int CTRL_ADDR_LSB = 8;
  localparam logic [14:0] CTRL_RESET = 15'h0004;
  // txcmd bits
  localparam int CMD_START = 0;
  localparam int CMD_RESP = 1;
  localparam int CMD_CLR = 2;
  localparam int CMD_RXDONE = 3;
endpackage

//--- hw/clsb_uart.sv
// character serializer / deserializer for one current-loop pair
// assumes rx_i is already synchronous to sys_clk and idles high (current on)
`timescale 1ns/1ps
module clsb_uart import clsb_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] baud_sel,
  input wire logic seven_bits,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic rx_i,
  output logic tx_o,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_strobe,
  output logic rx_err
);
  typedef struct packed {
    logic [17:0] tdiv;
    logic [3:0] tbits;
    logic [10:0] tsh;
    logic tbusy;
    logic [17:0] rdiv;
    logic [3:0] rbits;
    logic [9:0] rsh;
    logic rbusy;
    logic [7:0] rdat;
    logic rstb;
    logic rerr;
  } clsb_uart_type;
  clsb_uart_type s_q, s_d;
  logic [17:0] bit_cyc;
  logic [3:0] nbits;
  logic [7:0] dmask;
  assign bit_cyc = 18'(BAUD_300_CYC >> baud_sel);
  // data + parity + stop after start
  assign nbits = (seven_bits ? 4'h8 : 4'h9) + (par_en ? 4'h1 : 4'h0);
  assign dmask = seven_bits ? 8'h7f : 8'hff;
  assign tx_o = s_q.tbusy ? s_q.tsh[0] : 1'b1;
  assign tx_ready = !s_q.tbusy;
  assign rx_data = s_q.rdat;
  assign rx_strobe = s_q.rstb;
  assign rx_err = s_q.rerr;
  always_comb begin
    logic [7:0] d;
    logic [9:0] fr;
    logic p;
    d = 8'h00;
    fr = 10'h000;
    p = 1'b0;
    s_d = s_q;
    s_d.rstb = 1'b0;
    if (!s_q.tbusy) begin
      if (tx_valid) begin
        d = tx_data & dmask;
        p = ^d ^ par_odd;
        // lsb first, start bit low
        if (seven_bits) begin
          fr = par_en ? {1'b1, p, d[6:0], 1'b0} : {2'b11, d[6:0], 1'b0};
        end else begin
          fr = par_en ? {p, d, 1'b0} : {1'b1, d, 1'b0};
        end
        s_d.tsh = {1'b1, fr};
        s_d.tbits = nbits;
        s_d.tdiv = bit_cyc - 18'h1;
        s_d.tbusy = 1'b1;
      end
    end else if (s_q.tdiv != 18'h0) begin
      s_d.tdiv = s_q.tdiv - 18'h1;
    end else if (s_q.tbits == 4'h0) begin
      s_d.tbusy = 1'b0;
    end else begin
      s_d.tsh = {1'b1, s_q.tsh[10:1]};
      s_d.tbits = s_q.tbits - 4'h1;
      s_d.tdiv = bit_cyc - 18'h1;
    end
    if (!s_q.rbusy) begin
      if (!rx_i) begin
        s_d.rbusy = 1'b1;
        s_d.rdiv = bit_cyc + (bit_cyc >> 1);
        s_d.rbits = nbits;
        s_d.rsh = 10'h000;
      end
    end else if (s_q.rdiv != 18'h0) begin
      s_d.rdiv = s_q.rdiv - 18'h1;
    end else if (s_q.rbits != 4'h1) begin
      s_d.rsh = {rx_i, s_q.rsh[9:1]};
      s_d.rbits = s_q.rbits - 4'h1;
      s_d.rdiv = bit_cyc - 18'h1;
    end else begin
      // stop bit sample: align collected bits to bit 0
      fr = s_q.rsh >> (4'ha - nbits + 4'h1);
      d = seven_bits ? {1'b0, fr[6:0]} : fr[7:0];
      p = seven_bits ? fr[7] : fr[8];
      s_d.rbusy = 1'b0;
      s_d.rdat = d;
      s_d.rstb = 1'b1;
      s_d.rerr = !rx_i || (par_en && (p != (^d ^ par_odd)));
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

//--- hw/clsb_top.sv
// current-loop serial buffer: receive string buffer with editing, transmit buffer with delay/pause
// assumes classic wishbone master on sys_clk; string interpretation is done by software
`timescale 1ns/1ps
module clsb_top import clsb_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic loop_rx_i,
  output logic loop_tx_o
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_SEND = 5'b00010,
    TX_WAIT = 5'b00100,
    TX_DELAY = 5'b01000,
    TX_PAUSE = 5'b10000
  } clsb_txst_type;
  typedef struct packed {
    logic [14:0] ctrl;
    logic [7:0] term;
    logic [7:0] dly;
    logic [RX_DEPTH-1:0][7:0] rxm;
    logic [7:0] rx_len;
    logic rx_ready;
    logic rx_own;
    logic rx_drop;
    logic [7:0] rx_rd;
    logic [TX_DEPTH-1:0][7:0] txm;
    logic [7:0] tx_len;
    logic [7:0] tx_pos;
    logic tx_resp;
    logic tx_esc;
    logic tx_pause_req;
    logic tx_abort;
    logic [1:0] tx_tail;
    clsb_txst_type st;
    logic [7:0] dly_steps;
    logic [19:0] dly_cnt;
    logic ack;
    logic [31:0] rdat;
  } clsb_top_type;
  clsb_top_type s_q, s_d;
  logic tx_ready;
  logic [7:0] rx_byte;
  logic rx_stb;
  logic rx_err;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic [7:0] cur;
  logic [6:0] uaddr;
  logic [7:0] tens;
  logic [7:0] ones;
  // rates 300..38400 by shifting the 300-baud divider
  clsb_uart u_uart (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .baud_sel(s_q.ctrl[CTRL_BAUD_LSB +: 3]),
    .seven_bits(s_q.ctrl[CTRL_SEVEN]),
    .par_en(s_q.ctrl[CTRL_PAR_EN]),
    .par_odd(s_q.ctrl[CTRL_PAR_ODD]),
    .rx_i(loop_rx_i),
    .tx_o(loop_tx_o),
    .tx_valid(tx_valid),
    .tx_data(tx_byte),
    .tx_ready(tx_ready),
    .rx_data(rx_byte),
    .rx_strobe(rx_stb),
    .rx_err(rx_err)
  );
  assign uaddr = s_q.ctrl[CTRL_ADDR_LSB +: 7];
  assign tens = CH_ZERO + 8'(uaddr / 7'd10);
  assign ones = CH_ZERO + 8'(uaddr % 7'd10);
  assign cur = s_q.txm[s_q.tx_pos];
  // 14h is consumed as a delay, never sent
  assign tx_valid = (s_q.st == TX_SEND) && (s_q.tx_tail != 2'b00 || cur != CH_CTRL_T);
  assign tx_byte = (s_q.tx_tail == 2'b10) ? CH_CR : (s_q.tx_tail == 2'b01) ? CH_LF : cur;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;

  function automatic logic term_ok(input logic [7:0] t);
    // range check and excluded codes
    term_ok = t >= TERM_MIN && t <= TERM_MAX && t != CH_BS && t != CH_ESC && !(t >= CH_ZERO && t <= CH_NINE);
  endfunction

  always_comb begin
    logic req;
    logic [7:0] c;
    req = wb_cyc_i && wb_stb_i && !s_q.ack;
    c = rx_byte;
    s_d = s_q;
    s_d.ack = req;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: s_d.rdat = {17'h0, s_q.ctrl};
        REG_TERM: s_d.rdat = {24'h0, s_q.term};
        REG_DELAY: s_d.rdat = {24'h0, s_q.dly};
        REG_STATUS: s_d.rdat = {11'h0, s_q.st, s_q.tx_len, s_q.rx_len[7:0]} | {s_q.rx_ready, s_q.rx_own, 30'h0};
        REG_RXDATA: s_d.rdat = {24'h0, s_q.rxm[s_q.rx_rd[6:0]]};
        default: s_d.rdat = 32'h0;
      endcase
      if (wb_adr_i == REG_RXDATA) begin
        s_d.rx_rd = s_q.rx_rd + 8'h1;
      end
    end
    if (req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        REG_CTRL: s_d.ctrl = {wb_dat_i[14:8] & {7{wb_sel_i[1]}} | s_q.ctrl[14:8] & {7{!wb_sel_i[1]}}, wb_dat_i[7:0]};
        // invalid terminators are refused
        REG_TERM: s_d.term = term_ok(wb_dat_i[7:0]) ? wb_dat_i[7:0] : s_q.term;
        // setting limited to 250 steps of 10 ms
        REG_DELAY: s_d.dly = wb_dat_i[7:0] > TX_DLY_MAX ? TX_DLY_MAX : wb_dat_i[7:0];
        REG_TXDATA: begin
          // string limited to 255 bytes
          if (s_q.st == TX_IDLE && s_q.tx_len < 8'(TX_MAX_LEN)) begin
            s_d.txm[s_q.tx_len] = wb_dat_i[7:0];
            s_d.tx_len = s_q.tx_len + 8'h1;
          end
        end
        REG_TXCMD: begin
          if (wb_dat_i[CMD_CLR] && s_q.st == TX_IDLE) begin
            s_d.tx_len = 8'h00;
          end
          if (wb_dat_i[CMD_START] && s_q.st == TX_IDLE && s_q.tx_len != 8'h0) begin
            s_d.st = TX_SEND;
            s_d.tx_pos = 8'h00;
            s_d.tx_resp = wb_dat_i[CMD_RESP];
            s_d.tx_esc = 1'b0;
            s_d.tx_pause_req = 1'b0;
            s_d.tx_tail = 2'b00;
          end
          if (wb_dat_i[CMD_RXDONE]) begin
            // software consumed or discarded the string
            s_d.rx_ready = 1'b0;
            s_d.rx_len = 8'h00;
            s_d.rx_rd = 8'h00;
          end
        end
        default: ;
      endcase
    end
    // receive side runs alongside transmit
    if (rx_stb && !rx_err) begin
      if (s_q.st == TX_PAUSE && c == CH_ESC) begin
        s_d.tx_abort = 1'b1;
      end else if (s_q.st == TX_PAUSE && c == CH_CR) begin
        s_d.st = TX_SEND;
      end else if (s_q.tx_resp && s_q.st != TX_IDLE && c == CH_ESC) begin
        s_d.tx_pause_req = 1'b1;
      end else if (s_q.st == TX_PAUSE || s_q.rx_ready) begin
        // paused or string pending: new input not taken
      end else if (c == CH_BS) begin
        if (s_q.rx_len != 8'h0) begin
          s_d.rx_len = s_q.rx_len - 8'h1;
        end
      end else if (c == CH_ESC) begin
        s_d.rx_len = 8'h00;
      end else if (c == CH_CTRL_N && s_q.ctrl[CTRL_LOOPMODE]) begin
        s_d.rxm[0] = CH_N;
        s_d.rxm[1] = tens;
        s_d.rxm[2] = ones;
        s_d.rx_len = 8'h03;
      end else if (c == CH_NULL || c == s_q.term || (s_q.ctrl[CTRL_COLLECT] && c == CH_CR)) begin
        // terminator, universal null or collect-mode cr
        s_d.rx_ready = 1'b1;
        s_d.rx_rd = 8'h00;
        // prefix check: zero address needs none
        if (s_q.rx_len >= 8'h3 && s_q.rxm[0] == CH_N) begin
          s_d.rx_own = s_q.rxm[1] == tens && s_q.rxm[2] == ones;
        end else begin
          s_d.rx_own = uaddr == 7'h0;
        end
      end else if (s_q.rx_len == 8'(RX_DEPTH)) begin
        s_d.rxm[0] = c;
        s_d.rx_len = 8'h01;
      end else begin
        s_d.rxm[s_q.rx_len[6:0]] = c;
        s_d.rx_len = s_q.rx_len + 8'h1;
      end
    end
    // address prefix of form N + two digits; insertion assumes it sits at the start
    case (s_q.st)
      TX_IDLE: ;
      TX_SEND: begin
        if (s_q.tx_tail == 2'b00 && cur == CH_CTRL_T) begin
          s_d.st = TX_DELAY;
          s_d.tx_pos = s_q.tx_pos + 8'h1;
          s_d.dly_steps = s_q.dly;
          s_d.dly_cnt = 20'(TX_DLY_STEP_CYC);
        end else if (tx_ready) begin
          s_d.st = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (tx_ready) begin
          s_d.dly_steps = s_q.dly;
          s_d.dly_cnt = 20'(TX_DLY_STEP_CYC);
          if (s_q.tx_tail == 2'b10) begin
            s_d.tx_tail = 2'b01;
            s_d.st = TX_SEND;
          end else if (s_q.tx_tail == 2'b01) begin
            s_d.st = TX_DELAY; // closing pair then delay
            s_d.tx_pos = s_q.tx_len;
          end else begin
            s_d.tx_pos = s_q.tx_pos + 8'h1;
            // delay after string end and after lf of a response
            if (s_q.tx_pos + 8'h1 == s_q.tx_len || (s_q.tx_resp && cur == CH_LF)) begin
              s_d.st = TX_DELAY;
            end else begin
              s_d.st = TX_SEND;
            end
          end
        end
      end
      TX_DELAY: begin
        if (s_q.dly_steps == 8'h0) begin
          if (s_q.tx_pos >= s_q.tx_len) begin
            s_d.st = TX_IDLE;
            s_d.tx_len = 8'h00;
          end else if (s_q.tx_pause_req && s_q.tx_resp && s_q.txm[s_q.tx_pos - 8'h1] == CH_LF) begin
            s_d.st = TX_PAUSE; // line end reached
            s_d.tx_pause_req = 1'b0;
          end else begin
            s_d.st = TX_SEND;
          end
        end else if (s_q.dly_cnt == 20'h1) begin
          s_d.dly_cnt = 20'(TX_DLY_STEP_CYC);
          s_d.dly_steps = s_q.dly_steps - 8'h1;
        end else begin
          s_d.dly_cnt = s_q.dly_cnt - 20'h1;
        end
      end
      TX_PAUSE: begin
        if (s_q.tx_abort) begin
          s_d.tx_abort = 1'b0;
          s_d.tx_tail = 2'b10;
          s_d.st = TX_SEND;
        end
      end
      default: s_d.st = TX_IDLE;
    endcase
  end
  // terminator default asterisk, also closes outgoing strings by software
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.term <= TERM_RESET;
      s_q.st <= TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

//--- tb/clsb_top_monitor.sv
// checker for the serial buffer top: bus handshake, register read-back and line timing
// assumes it is bound to clsb_top and sees only its ports
`timescale 1ns/1ps
module clsb_monitor import clsb_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic loop_rx_i,
  input wire logic loop_tx_o
);
  logic [2:0] baud_q;
  logic [7:0] term_q;
  logic [7:0] dly_q;
  logic last_q;
  int run_q;
  int bit_cyc;
  logic wr_ev;
  assign bit_cyc = BAUD_300_CYC >> baud_q;
  assign wr_ev = wb_ack_o && wb_we_i && wb_sel_i[0];
  function automatic logic term_ok(input logic [7:0] t);
    return t >= TERM_MIN && t <= TERM_MAX && t != CH_BS && t != CH_ESC && (t < CH_ZERO || t > CH_NINE);
  endfunction
  // shadows follow the writes so read-back can be judged without the design's state
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      baud_q <= CTRL_RESET[2:0];
      term_q <= TERM_RESET;
      dly_q <= 8'h00;
      last_q <= 1'b1;
      run_q <= 1000000;
    end else begin
      if (wr_ev && wb_adr_i == REG_CTRL) baud_q <= wb_dat_i[2:0];
      if (wr_ev && wb_adr_i == REG_TERM && term_ok(wb_dat_i[7:0])) term_q <= wb_dat_i[7:0];
      if (wr_ev && wb_adr_i == REG_DELAY) dly_q <= (wb_dat_i[7:0] > TX_DLY_MAX) ? TX_DLY_MAX : wb_dat_i[7:0];
      last_q <= loop_tx_o;
      run_q <= (loop_tx_o != last_q) ? 1 : ((run_q < 1000000) ? run_q + 1 : run_q);
    end
  end
  ack_answer_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered next cycle");
  ack_single_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o && !wb_we_i && wb_adr_i > REG_TXCMD |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  reset_idle_a: assert property (@(posedge sys_clk)
    !resetn |=> loop_tx_o && !wb_ack_o) else $error("line or ack not idle in reset");
  term_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o && !wb_we_i && wb_adr_i == REG_TERM |-> wb_dat_o[7:0] == term_q) else $error("terminator read-back");
  delay_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o && !wb_we_i && wb_adr_i == REG_DELAY |-> wb_dat_o[7:0] == dly_q) else $error("delay read-back");
  bit_min_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    loop_tx_o != last_q |-> run_q >= bit_cyc - 2) else $error("line level shorter than one bit");
  low_max_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    loop_tx_o && !last_q |-> run_q <= 10 * bit_cyc + 20) else $error("space longer than a frame");
endmodule

bind clsb_top clsb_monitor u_clsb_monitor (.sys_clk(sys_clk), .resetn(resetn), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .loop_rx_i(loop_rx_i), .loop_tx_o(loop_tx_o));

//--- tb/clsb_host_model.sv
// host on the far end of the current loop: sends and collects 8n1 characters
// assumes both ends run the same bit time, given in sys_clk cycles
`timescale 1ns/1ps
module clsb_host_model #(
  parameter int BIT_CYC = 520
) (
  input wire logic sys_clk,
  input wire logic dev_tx,
  output logic dev_rx
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial dev_rx = 1'b1;
  // line marks between frames; gap lets the host answer slowly
  task automatic send(input logic [7:0] b, input int gap = 0);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    repeat (gap) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      dev_rx <= fr[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask
  initial forever begin
    @(posedge sys_clk);
    if (dev_tx === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge sys_clk);
        sh[i] = dev_tx;
      end
      repeat (BIT_CYC) @(posedge sys_clk);
      if (dev_tx === 1'b1) rx_q.push_back(sh);
    end
  end
endmodule

//--- tb/tb.sv
// self-checking bench: wishbone register tasks plus a serial host on the loop pair
// assumes 10 MHz sys_clk and the design's one-cycle ack
`timescale 1ns/1ps
module tb import clsb_pkg::*;;
  logic sys_clk, resetn, wb_we, wb_cyc, wb_stb, wb_ack_o, loop_rx, loop_tx;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_dat_o;
  logic [3:0] wb_sel;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] bad[7] = '{8'h08, 8'h1b, 8'h30, 8'h39, 8'h41, 8'hff, 8'h00};
  logic [7:0] good[4] = '{8'h01, 8'h40, 8'h0d, 8'h2a};
  logic [7:0] pfx[3] = '{CH_N, 8'h33, 8'h34};
  logic [7:0] txs[4] = '{8'h48, CH_CTRL_T, 8'h49, CH_STAR};
  logic [7:0] rsp[2] = '{CH_LF, 8'h42};
  clsb_top u_clsb_top (.sys_clk(sys_clk), .resetn(resetn), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_ack_o(wb_ack_o), .loop_rx_i(loop_rx), .loop_tx_o(loop_tx));
  clsb_host_model #(.BIT_CYC(BAUD_300_CYC >> 6)) u_host (.sys_clk(sys_clk), .dev_tx(loop_tx), .dev_rx(loop_rx));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_adr <= a;
    wb_we <= we;
    wb_dat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 100) chk("bus ack", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input string w, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(w, e, q & m);
  endtask
  initial begin
    int n;
    resetn = 1'b0;
    {wb_we, wb_cyc, wb_stb} = 3'h0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    wb_sel = 4'hf;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rd("ctrl reset", REG_CTRL, 32'h7fff, {17'h0, CTRL_RESET});
    rd("term reset", REG_TERM, 32'hff, {24'h0, TERM_RESET});
    rd("delay reset", REG_DELAY, 32'hff, 32'h0);
    rd("status reset", REG_STATUS, 32'h801fffff, 32'h00010000);
    rd("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    wr(REG_CTRL, 32'h6); // 19200 8n1, address zero
    foreach (bad[i]) begin
      wr(REG_TERM, {24'h0, bad[i]});
      rd("term refused", REG_TERM, 32'hff, 32'h2a);
    end
    foreach (good[i]) begin
      wr(REG_TERM, {24'h0, good[i]});
      rd("term taken", REG_TERM, 32'hff, {24'h0, good[i]});
    end
    wr(REG_DELAY, 32'hfb);
    rd("delay clamp", REG_DELAY, 32'hff, 32'hfa);
    wr(REG_DELAY, 32'h0);
    u_host.send(8'h41);
    u_host.send(8'h42, 300);
    u_host.send(CH_BS);
    rd("rx len after backspace", REG_STATUS, 32'h800000ff, 32'h1);
    u_host.send(CH_ESC);
    u_host.send(CH_BS);
    rd("rx len after escape", REG_STATUS, 32'h800000ff, 32'h0);
    u_host.send(8'h58);
    u_host.send(CH_STAR);
    rd("string ready", REG_STATUS, 32'hc0000000, 32'hc0000000);
    rd("rx first byte", REG_RXDATA, 32'hff, 32'h58);
    wr(REG_TXCMD, 32'h8);
    rd("string released", REG_STATUS, 32'h80000000, 32'h0);
    u_host.send(8'h51);
    u_host.send(CH_NULL);
    rd("null ends string", REG_STATUS, 32'h80000000, 32'h80000000);
    wr(REG_TXCMD, 32'h8);
    wr(REG_CTRL, 32'h2246); // addressed loop mode, unit 34
    u_host.send(CH_CTRL_N);
    u_host.send(CH_STAR);
    rd("own address", REG_STATUS, 32'hc0000000, 32'hc0000000);
    foreach (pfx[i]) rd("address prefix", REG_RXDATA, 32'hff, {24'h0, pfx[i]});
    wr(REG_TXCMD, 32'h8);
    foreach (txs[i]) wr(REG_TXDATA, {24'h0, txs[i]});
    wr(REG_TXCMD, 32'h1);
    n = 0;
    while (u_host.rx_q.size() < 3 && n < 40000) begin
      @(posedge sys_clk);
      n++;
    end
    // host takes the byte at mid stop bit; let the stop bit and the delay state run out
    repeat (BAUD_300_CYC >> 6) @(posedge sys_clk);
    rd("tx back to idle", REG_STATUS, 32'h001f0000, 32'h00010000);
    chk("tx count", 32'h3, u_host.rx_q.size());
    for (int i = 0; i < 3 && i < u_host.rx_q.size(); i++) begin
      chk("tx byte", {24'h0, (i < 2) ? 8'h48 + i[7:0] : CH_STAR}, {24'h0, u_host.rx_q[i]});
    end
    // response of one line: escape during the lf pauses, a second escape aborts
    foreach (rsp[i]) wr(REG_TXDATA, {24'h0, rsp[i]});
    wr(REG_TXCMD, 32'h3);
    u_host.send(CH_ESC);
    repeat (20) @(posedge sys_clk);
    rd("tx paused at line end", REG_STATUS, 32'h001f0000, 32'h00100000);
    u_host.send(CH_ESC);
    n = 0;
    while (u_host.rx_q.size() < 6 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (BAUD_300_CYC >> 6) @(posedge sys_clk);
    rd("abort back to idle", REG_STATUS, 32'h001f0000, 32'h00010000);
    chk("abort count", 32'h6, u_host.rx_q.size());
    for (int i = 3; i < 6 && i < u_host.rx_q.size(); i++) begin
      chk("abort byte", {24'h0, (i == 4) ? CH_CR : CH_LF}, {24'h0, u_host.rx_q[i]});
    end
    print_verdict();
  end
  initial begin
    repeat (104000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
endmodule
